/* src/external_pin_change_irq.sv */
// external line and pin-change interrupt logic
// assumes: register port with read data one cycle after the read strobe;
// the core pulses vector_taken when it enters an interrupt routine
`timescale 1ns/10ps
`default_nettype none
module external_pin_change_irq
   import pin_irq_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic ext_line_zero,
   input wire logic ext_line_one,
   input wire logic [all_pins-1:0] change_inputs_all,
   input wire logic global_irq_enable,
   input wire logic [event_bits-1:0] vector_taken,
   output logic [event_bits-1:0] vector_request,
   output logic pin_wake,
   output logic irq
);
   // event order in vector_request / vector_taken / status:
   // 0 line zero, 1 line one, 2 bank0, 3 bank1, 4 bank2
   typedef struct packed {
      logic [3:0] sense;
      logic [1:0] line_en;
      logic [1:0] line_pend;
      logic [2:0] bank_en;
      logic [2:0] bank_pend;
      logic [7:0] mask0;
      logic [7:0] mask1;
      logic [7:0] mask2;
      logic [event_bits-1:0] irq_mask;
      logic [7:0] rdata;
      logic [event_bits-1:0] req;
      logic wake;
      logic irq;
   } state_t;

   state_t st;
   state_t next_st;
   pin_sync_bus sync ();
   logic [ext_lines-1:0] line_now;
   logic [ext_lines-1:0] line_was;
   logic [ext_lines-1:0] line_hit;
   logic [ext_lines-1:0] line_level_req;
   logic [all_pins-1:0] pin_toggle;
   logic [all_pins-1:0] pin_mask;
   logic [banks-1:0] bank_hit;
   logic [event_bits-1:0] status_now;
   logic [event_bits-1:0] active;

   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   pin_sampler sampler_i (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .raw_pins({ext_line_one, ext_line_zero, change_inputs_all}),
      .sync(sync)
   );

   assign line_now = sync.now_level[all_pins+ext_lines-1:all_pins];
   assign line_was = sync.was_level[all_pins+ext_lines-1:all_pins];
   assign pin_mask = {st.mask2, st.mask1 & mask_bank1_used, st.mask0};

   // ---------------------------------------------------------------
   // external line sense decode
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < ext_lines; gi++) begin : g_line
         sense_t mode;
         assign mode = sense_t'(st.sense[2*gi +: 2]);
         assign line_hit[gi] = sync.primed &&
            ((mode == sense_change && line_now[gi] != line_was[gi]) ||
             (mode == sense_fall && !line_now[gi] && line_was[gi]) ||
             (mode == sense_rise && line_now[gi] && !line_was[gi]));
         assign line_level_req[gi] = (mode == sense_low) && !line_now[gi];
      end
      // per-pin toggle detect, gated by its mask bit
      for (gi = 0; gi < all_pins; gi++) begin : g_pin
         assign pin_toggle[gi] = sync.primed && pin_mask[gi] &&
            (sync.now_level[gi] != sync.was_level[gi]);
      end
      for (gi = 0; gi < banks; gi++) begin : g_bank
         assign bank_hit[gi] = st.bank_en[gi] &&
            (|pin_toggle[gi*bank_pins +: bank_pins]);
      end
   endgenerate

   // level lines request straight from the pin, edges through the flag
   assign status_now = {st.bank_pend, st.line_pend | line_level_req};
   assign active = status_now & {st.bank_en, st.line_en};

   // ---------------------------------------------------------------
   // next state: registers, flags, requests
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      // software writes; write-one clears flags
      if (reg_write) begin
         case (reg_addr)
            sense_ctrl_addr: next_st.sense = reg_wdata[3:0];
            line_enable_addr: next_st.line_en = reg_wdata[1:0];
            ext_flags_addr: next_st.line_pend = st.line_pend & ~reg_wdata[1:0];
            bank_enable_addr: next_st.bank_en = reg_wdata[2:0];
            bank_flags_addr: next_st.bank_pend = st.bank_pend & ~reg_wdata[2:0];
            mask_bank0_addr: next_st.mask0 = reg_wdata;
            mask_bank1_addr: next_st.mask1 = reg_wdata & mask_bank1_used;
            mask_bank2_addr: next_st.mask2 = reg_wdata;
            irq_mask_addr: next_st.irq_mask = reg_wdata[event_bits-1:0];
            default: next_st.sense = st.sense;
         endcase
      end
      // vector entry clears its flag
      next_st.line_pend = next_st.line_pend & ~vector_taken[1:0];
      next_st.bank_pend = next_st.bank_pend & ~vector_taken[4:2];
      // hardware sets last so they win over write-one and vector-entry clears
      next_st.line_pend = next_st.line_pend | line_hit;
      next_st.bank_pend = next_st.bank_pend | bank_hit;
      // low-level mode never keeps a latched flag
      for (int i = 0; i < ext_lines; i++) begin
         if (sense_t'(next_st.sense[2*i +: 2]) == sense_low) begin
            next_st.line_pend[i] = 1'b0;
         end
      end
      // read data, one cycle after the strobe
      next_st.rdata = zero_byte;
      if (reg_read) begin
         case (reg_addr)
            sense_ctrl_addr: next_st.rdata = {4'h0, st.sense};
            line_enable_addr: next_st.rdata = {6'h00, st.line_en};
            ext_flags_addr: next_st.rdata = {6'h00, st.line_pend};
            bank_enable_addr: next_st.rdata = {5'h00, st.bank_en};
            bank_flags_addr: next_st.rdata = {5'h00, st.bank_pend};
            mask_bank0_addr: next_st.rdata = st.mask0;
            mask_bank1_addr: next_st.rdata = st.mask1 & mask_bank1_used;
            mask_bank2_addr: next_st.rdata = st.mask2;
            irq_mask_addr: next_st.rdata = {3'h0, st.irq_mask};
            pin_level_addr: next_st.rdata = {3'h0, status_now};
            default: next_st.rdata = zero_byte;
         endcase
      end
      // vector requests gated by global enable
      next_st.req = global_irq_enable ? active : '0;
      // wake needs no global enable; works as a raw event
      next_st.wake = |active;
      next_st.irq = |(status_now & st.irq_mask);
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign vector_request = st.req;
   assign pin_wake = st.wake;
   assign irq = st.irq;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_line_set;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && line_hit[0] &&
       !(reg_write && reg_addr == sense_ctrl_addr)) |=> st.line_pend[0];
   endproperty
   a_line_set: assert property (p_line_set)
      else $error("line zero edge did not set pending");

   property p_request;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && global_irq_enable && st.line_en[0] && st.line_pend[0])
      |=> vector_request[0];
   endproperty
   a_request: assert property (p_request)
      else $error("line zero request missing");

   property p_vector_clear;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && vector_taken[2] && !bank_hit[0]) |=> !st.bank_pend[0];
   endproperty
   a_vector_clear: assert property (p_vector_clear)
      else $error("vector entry did not clear bank zero flag");

   property p_w1c;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && reg_write && reg_addr == bank_flags_addr &&
       reg_wdata[1] && !bank_hit[1]) |=> !st.bank_pend[1];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("write one did not clear bank one flag");

   property p_level_zero;
      @(posedge clk) disable iff (sys_rst)
      (st.sense[1:0] == sense_low) |-> !st.line_pend[0];
   endproperty
   a_level_zero: assert property (p_level_zero)
      else $error("level mode flag not zero");

   property p_reserved;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && reg_read && reg_addr == bank_flags_addr)
      |=> reg_rdata[7:3] == 5'h00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits read nonzero");

   property p_mask1_top;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && reg_read && reg_addr == mask_bank1_addr) |=> !reg_rdata[7];
   endproperty
   a_mask1_top: assert property (p_mask1_top)
      else $error("bank one mask bit seven read set");

   property p_set_wins;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && bank_hit[2] && vector_taken[4]) |=> st.bank_pend[2];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear beat a set on bank two");

   property p_masked_pin;
      @(posedge clk) disable iff (sys_rst)
      (st.mask0 == 8'h00) |-> !bank_hit[0];
   endproperty
   a_masked_pin: assert property (p_masked_pin)
      else $error("masked bank raised a change");

   property p_line_one_set;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && line_hit[1] &&
       !(reg_write && reg_addr == sense_ctrl_addr)) |=> st.line_pend[1];
   endproperty
   a_line_one_set: assert property (p_line_one_set)
      else $error("line one edge did not set pending");

   property p_no_global;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && !global_irq_enable) |=> vector_request == '0;
   endproperty
   a_no_global: assert property (p_no_global)
      else $error("request raised without global enable");

   property p_line_vector_clear;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && vector_taken[0] && !line_hit[0]) |=> !st.line_pend[0];
   endproperty
   a_line_vector_clear: assert property (p_line_vector_clear)
      else $error("vector entry did not clear line zero flag");

   property p_line_w1c;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && reg_write && reg_addr == ext_flags_addr &&
       reg_wdata[0] && !line_hit[0]) |=> !st.line_pend[0];
   endproperty
   a_line_w1c: assert property (p_line_w1c)
      else $error("write one did not clear line zero flag");

   property p_level_request;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && global_irq_enable && st.line_en[0] &&
       st.sense[1:0] == sense_low && !line_now[0]) |=> vector_request[0];
   endproperty
   a_level_request: assert property (p_level_request)
      else $error("low level did not request line zero");

   property p_ext_reserved;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && reg_read && reg_addr == ext_flags_addr)
      |=> reg_rdata[7:2] == 6'h00;
   endproperty
   a_ext_reserved: assert property (p_ext_reserved)
      else $error("line flag reserved bits read nonzero");

   property p_bank2_request;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && global_irq_enable && st.bank_en[2] && st.bank_pend[2])
      |=> vector_request[4];
   endproperty
   a_bank2_request: assert property (p_bank2_request)
      else $error("bank two request missing");

   property p_bank1_request;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && global_irq_enable && st.bank_en[1] && st.bank_pend[1])
      |=> vector_request[3];
   endproperty
   a_bank1_request: assert property (p_bank1_request)
      else $error("bank one request missing");

   property p_bank0_request;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && global_irq_enable && st.bank_en[0] && st.bank_pend[0])
      |=> vector_request[2];
   endproperty
   a_bank0_request: assert property (p_bank0_request)
      else $error("bank zero request missing");

   property p_bank_set;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && bank_hit[0]) |=> st.bank_pend[0];
   endproperty
   a_bank_set: assert property (p_bank_set)
      else $error("bank zero change did not set pending");

   property p_rise_only;
      @(posedge clk) disable iff (sys_rst)
      (sync.primed && st.sense[3:2] == sense_rise &&
       !line_now[1] && line_was[1]) |-> !line_hit[1];
   endproperty
   a_rise_only: assert property (p_rise_only)
      else $error("rising mode reacted to a falling edge");

   property p_wake;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && |active) |=> pin_wake;
   endproperty
   a_wake: assert property (p_wake)
      else $error("enabled request did not raise wake");
endmodule : external_pin_change_irq
`default_nettype wire

/* src/pin_irq_pkg.sv */
// package for the external and pin-change interrupt block
// assumes: an 8-bit register port, one 125 MHz clock, synchronous reset
package pin_irq_pkg;
   // register indices on the plain register port
   localparam logic [3:0] sense_ctrl_addr = 4'h0;
   localparam logic [3:0] line_enable_addr = 4'h1;
   localparam logic [3:0] ext_flags_addr = 4'h2;
   localparam logic [3:0] bank_enable_addr = 4'h3;
   localparam logic [3:0] bank_flags_addr = 4'h4;
   localparam logic [3:0] mask_bank0_addr = 4'h5;
   localparam logic [3:0] mask_bank1_addr = 4'h6;
   localparam logic [3:0] mask_bank2_addr = 4'h7;
   localparam logic [3:0] irq_mask_addr = 4'h8;
   localparam logic [3:0] pin_level_addr = 4'h9;
   // field layouts and widths
   localparam int ext_lines = 2;
   localparam int banks = 3;
   localparam int bank_pins = 8;
   localparam int all_pins = 24;
   localparam int event_bits = 5;
   localparam logic [7:0] mask_bank1_used = 8'h7f;
   localparam logic [7:0] reg_reset = 8'h00;
   localparam logic [7:0] zero_byte = 8'h00;
   // edges after reset until every sampler stage holds a real sample
   localparam logic [1:0] sampler_fill = 2'h3;
   // sense modes of an external line
   typedef enum logic [1:0] {
      sense_low = 2'b00,
      sense_change = 2'b01,
      sense_fall = 2'b10,
      sense_rise = 2'b11
   } sense_t;
   // state of the pin sampler
   typedef struct packed {
      logic [all_pins+ext_lines-1:0] stage1;
      logic [all_pins+ext_lines-1:0] stage2;
      logic [all_pins+ext_lines-1:0] stage3;
      logic [1:0] fill;
   } sampler_t;
endpackage : pin_irq_pkg

/* src/pin_sync_bus.sv */
// carrier between the top and the pin sampler
// assumes: one clock domain shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface pin_sync_bus;
   import pin_irq_pkg::*;
   logic [all_pins+ext_lines-1:0] now_level;
   logic [all_pins+ext_lines-1:0] was_level;
   logic primed;
   modport sampler (output now_level, output was_level, output primed);
   modport user (input now_level, input was_level, input primed);
endinterface : pin_sync_bus
`default_nettype wire

/* src/pin_sampler.sv */
// three-stage sampler for asynchronous pins with a previous-sample copy
// assumes: raw pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module pin_sampler
   import pin_irq_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [all_pins+ext_lines-1:0] raw_pins,
   pin_sync_bus.sampler sync
);
   sampler_t st;
   sampler_t next_st;

   // ---------------------------------------------------------------
   // sampling chain
   // ---------------------------------------------------------------
   // stage1 only feeds stage2; stage2 and stage3 differing is a settled change
   always_comb begin
      next_st = st;
      next_st.stage1 = raw_pins;
      next_st.stage2 = st.stage1;
      next_st.stage3 = st.stage2;
      // edges are trusted only once stage3 holds a real sample, so the
      // zeros left by reset never look like a change on an idle-high pin
      if (st.fill != sampler_fill) begin
         next_st.fill = st.fill + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // current sample is stage2, previous is stage3
   assign sync.now_level = st.stage2;
   assign sync.was_level = st.stage3;
   assign sync.primed = (st.fill == sampler_fill);
endmodule : pin_sampler
`default_nettype wire

/* test/pin_core_model.sv */
// far side model: the i/o pins and the core interrupt sequencer
// assumes: the bench plans pin levels; one clock shared with the block
`timescale 1ns/10ps
`default_nettype none
module pin_core_model
   import pin_irq_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [all_pins+ext_lines-1:0] pin_plan,
   input wire logic auto_take,
   input wire logic [event_bits-1:0] vector_request,
   output logic ext_line_zero,
   output logic ext_line_one,
   output logic [all_pins-1:0] change_inputs_all,
   output logic [event_bits-1:0] vector_taken
);
   logic [1:0] gap;
   // pins follow the plan; each level is held for many cycles
   always_ff @(posedge clk) begin
      {ext_line_one, ext_line_zero, change_inputs_all} <= pin_plan;
   end
   // enter the lowest requested routine, then pause while it clears
   always_ff @(posedge clk) begin
      vector_taken <= '0;
      if (sys_rst) begin
         gap <= 2'd0;
      end else if (gap != 2'd0) begin
         gap <= gap - 2'd1;
      end else if (auto_take && vector_request != '0) begin
         vector_taken <= vector_request & (~vector_request + 5'h01);
         gap <= 2'd3; // request drops two edges after the take
      end
   end
endmodule : pin_core_model
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the external and pin-change interrupt block
// assumes: the pin and sequencer model stands at the far side
`timescale 1ns/10ps
`default_nettype none
module tb;
   import pin_irq_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic gie = 1'b0;
   logic auto_take = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [25:0] pins = 26'h3000000; // both lines idle high
   logic line0, line1, pin_wake, irq;
   logic [23:0] chg;
   logic [4:0] vt, vr;
   logic [7:0] seed = 8'h63;
   logic [7:0] m, e;
   logic [2:0] en;
   int num_errors = 0;
   int comparisons = 0;
   int b, p;
   int takes = 0;
   always #4 clk = ~clk;
   // count routine entries made by the sequencer model
   always @(posedge clk) begin
      if (vt != 5'h00) begin
         takes <= takes + 1;
      end
   end
   pin_core_model u_model (.clk(clk), .sys_rst(sys_rst), .pin_plan(pins),
      .auto_take(auto_take), .vector_request(vr), .ext_line_zero(line0),
      .ext_line_one(line1), .change_inputs_all(chg), .vector_taken(vt));
   external_pin_change_irq u_dut (.clk(clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .ext_line_zero(line0), .ext_line_one(line1), .change_inputs_all(chg),
      .global_irq_enable(gie), .vector_taken(vt), .vector_request(vr),
      .pin_wake(pin_wake), .irq(irq));
   // ------------------------------------------------------------
   // compare, bus and expectation helpers
   // ------------------------------------------------------------
   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_reg
   task automatic check_out(input logic [4:0] got, input logic [4:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_out
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 check_reg(reg_rdata, exp);
   endtask : rd_check
   task automatic set_pin(input int idx, input logic v);
      @(posedge clk);
      pins[idx] <= v;
      repeat (8) @(posedge clk); // sampling plus flag latency
      #1;
   endtask : set_pin
   // vector entry on a bank flag; with two hits the second toggle lands on
   // the very edge at which the entry clears the flag, so two entries follow
   task automatic take_bank(input int bk, input int hits);
      int t0;
      wr(bank_enable_addr, 8'h07);
      wr(bank_flags_addr, 8'h07);
      wr(mask_bank0_addr + 4'(bk), 8'h01);
      t0 = takes;
      auto_take <= 1'b1;
      @(posedge clk);
      pins[bk * 8] <= ~pins[bk * 8];
      repeat (3) @(posedge clk);
      if (hits > 1) begin
         pins[bk * 8] <= ~pins[bk * 8];
      end
      repeat (20) @(posedge clk);
      auto_take <= 1'b0;
      #1 check_out(5'(takes - t0), 5'(hits));
      check_out(vr, 5'h00);
   endtask : take_bank
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // bank flag expected after one toggle of pin p in bank bk
   function automatic logic [7:0] exp_bank(input logic [7:0] mk,
         input logic [2:0] ena, input int bk, input int pn);
      logic [7:0] mu;
      mu = (bk == 1) ? (mk & mask_bank1_used) : mk;
      return (ena[bk] && mu[pn]) ? (8'h01 << bk) : zero_byte;
   endfunction : exp_bank
   task automatic complete_run;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   // watchdog well beyond the length of the sequence
   initial begin
      #(8 * 6000);
      num_errors++;
      complete_run();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 9; a++) rd_check(a[3:0], reg_reset);
      rd_check(4'hf, zero_byte); // unmapped index reads zero
      wr(line_enable_addr, 8'hff);
      rd_check(line_enable_addr, 8'h03);
      wr(bank_enable_addr, 8'hff);
      rd_check(bank_enable_addr, 8'h07);
      wr(mask_bank1_addr, 8'hff);
      rd_check(mask_bank1_addr, mask_bank1_used);
      // change, fall and rise modes on each line
      for (int l = 0; l < 2; l++) begin
         for (int md = 1; md < 4; md++) begin
            wr(sense_ctrl_addr, 8'(md << (2 * l)));
            wr(ext_flags_addr, 8'h03);
            set_pin(24 + l, 1'b0);
            e = (md != 3) ? 8'(1 << l) : zero_byte;
            rd_check(ext_flags_addr, e);
            wr(ext_flags_addr, 8'h00);
            rd_check(ext_flags_addr, e);
            wr(ext_flags_addr, 8'h03);
            rd_check(ext_flags_addr, zero_byte);
            set_pin(24 + l, 1'b1);
            e = (md != 2) ? 8'(1 << l) : zero_byte;
            rd_check(ext_flags_addr, e);
         end
      end
      // low level requests directly, flag stays zero
      wr(sense_ctrl_addr, 8'h00);
      wr(ext_flags_addr, 8'h03);
      gie <= 1'b1;
      set_pin(24, 1'b0);
      rd_check(ext_flags_addr, zero_byte);
      check_out(vr, 5'h01);
      set_pin(24, 1'b1);
      check_out(vr, 5'h00);
      // latched request, global gate, irq line, vector entry
      wr(sense_ctrl_addr, 8'h0e);
      set_pin(24, 1'b0);
      check_out(vr, 5'h01);
      check_out({3'b000, pin_wake, irq}, 5'h02); // irq masked off
      gie <= 1'b0;
      wr(irq_mask_addr, 8'h01);
      @(posedge clk);
      #1 check_out({3'b000, pin_wake, irq}, 5'h03); // unmasked status
      check_out(vr, 5'h00);
      gie <= 1'b1;
      auto_take <= 1'b1;
      set_pin(24, 1'b1);
      rd_check(ext_flags_addr, zero_byte);
      check_out({3'b000, pin_wake, irq}, 5'h00); // status cleared
      auto_take <= 1'b0;
      // random masks and enables, one toggle per trial
      for (int i = 0; i < 12; i++) begin
         b = i % 3;
         seed = lfsr(seed);
         m = seed;
         seed = lfsr(seed);
         en = seed[2:0];
         p = seed[5:3];
         if (i == 4) begin
            m = 8'hff; // unused pin of bank one
            en = 3'h7;
            p = 7;
         end
         wr(bank_enable_addr, {5'b00000, en});
         wr(mask_bank0_addr + b[3:0], m);
         wr(bank_flags_addr, 8'h07);
         set_pin(b * 8 + p, ~pins[b * 8 + p]);
         e = exp_bank(m, en, b, p);
         rd_check(bank_flags_addr, e);
         check_out(vr, {e[2:0], 2'b00});
      end
      // vector entry clears a flag; a set on the clearing edge wins
      take_bank(0, 1);
      take_bank(2, 2);
      rd_check(bank_flags_addr, zero_byte);
      // with the clock enable low a write-one clear is ignored
      set_pin(0, ~pins[0]);
      clk_en <= 1'b0;
      wr(bank_flags_addr, 8'h07);
      clk_en <= 1'b1;
      rd_check(bank_flags_addr, 8'h01);
      rd_check(pin_level_addr, 8'h04);
      complete_run();
   end
endmodule : tb
`default_nettype wire
